// ==== tca_cfg.svh ====
// Purpose: Constants for the temperature measurement and alert control block
// Assumes: 50 MHz hclk, AHB-Lite register access
// Notes:   Offsets are byte addresses of word registers
`ifndef TCA_CFG_SVH
`define TCA_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TCA_OFS_CFG1       8'h00
`define TCA_OFS_CFG2       8'h04
`define TCA_OFS_LIMIT_LOW  8'h08
`define TCA_OFS_LIMIT_HIGH 8'h0C
`define TCA_OFS_RESULT     8'h10
`define TCA_OFS_STATUS     8'h14
`define TCA_OFS_COMMAND    8'h18
`define TCA_OFS_RATE       8'h1C
`define TCA_OFS_SHORT_ADDR 8'h20
`define TCA_OFS_NV_SCHEME  8'h24

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TCA_CFG1_SCHEME_LSB 0
`define TCA_CFG1_AVG_BIT    3
`define TCA_CFG1_AMODE_BIT  4
`define TCA_CFG1_PINEN_BIT  5
`define TCA_CMD_START_BIT   0
`define TCA_CMD_SEARCH_BIT  1
`define TCA_STAT_ALERT_BIT  0
`define TCA_STAT_HIGH_BIT   1
`define TCA_STAT_LOW_BIT    2
`define TCA_STAT_BUSY_BIT   3
`define TCA_STAT_VDD_BIT    4
`define TCA_STAT_CONT_BIT   5

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define TCA_SCHEME_ONESHOT 3'h0
`define TCA_SCHEME_STAGGER 3'h1
`define TCA_SCHEME_AUTO    3'h2
`define TCA_RST_LIMIT_LOW  16'h8000
`define TCA_RST_LIMIT_HIGH 16'h7FFF
`define TCA_RST_RATE       16'h0010
`define TCA_AVG_SAMPLES    8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TCA_CLK_MHZ        50
`define TCA_TICK_US        1
`define TCA_TICK_CYCLES    (`TCA_TICK_US * `TCA_CLK_MHZ)
`define TCA_SLOT_TICKS     16'h0020

`endif

// ==== tca_ctrl.sv ====
// Purpose: Measurement scheme sequencing and threshold alert control
// Assumes: Sensor core answers each sample request with one done pulse
// Notes:   Registers reached over AHB-Lite, zero wait states, OKAY only
`timescale 1ns/10ps
`include "tca_cfg.svh"

// Overview of operation
// - Reset selects one-shot on request scheme
// - Shutdown between requests, one measurement each
// - Continuous scheme ignores single measurement requests
// - One sample, or average of eight
// - Scheme 10b bus powered measures automatically
// - Scheme 01b bus powered selects staggered
// - Staggered start delayed by short address
// - Supply powered nonzero scheme means continuous
// - Continuous repeats at interval, updates result
// - Each result compared, alert updated
// - Start function ignored while continuous
// - Scheme changes apply after current measurement, after one more when ending continuous or auto
// - Supply loss restores stored scheme setting
// - Flags always; pin only supply powered
// - Alert pin pulled low, open drain
// - Latched mode sets on limit crossing
// - Latched clears on status read, search
// - Comparator mode sets on same crossings
// - Comparator clears past limit minus hysteresis
// - Successful alert search clears alert flags in latched mode only
module tca_ctrl
    import tca_pkg::*;
#(
    parameter int SLOT_TICKS = 32
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        vdd_present,
    input  wire logic        search_done,
    input  wire logic        sample_done,
    input  wire logic [15:0] sample_value,
    output logic             sample_req,
    output logic             active_measure,
    output logic             alert_pin_oe,
    output logic             alert_pin_out
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [5:0]  cfg1;
    logic [7:0]  hyst;
    logic [15:0] limit_low;
    logic [15:0] limit_high;
    logic [15:0] result;
    logic [15:0] rate;
    logic [7:0]  short_addr;
    logic [2:0]  nv_scheme;
    logic        alert_flag;
    logic        high_flag;
    logic        low_flag;
    logic        start_pend;
    tca_state_type state;
    logic [15:0] wait_cnt;
    logic [3:0]  sample_cnt;
    logic [18:0] sum;
    logic [2:0]  run_scheme;
    logic        run_avg;
    logic        done_pulse;
    logic        req_wait;
    logic        vdd_s1;
    logic        vdd_s2;
    logic        vdd_prev;
    logic        srch_s1;
    logic        srch_s2;
    logic        srch_prev;
    logic        tick;
    logic        wr_pend;
    logic        rd_stat_pend;
    logic [7:0]  wr_addr;

    // ------------------------------------------------------------------
    // Tick divider
    // ------------------------------------------------------------------
    tca_tick_div #(
        .DIVIDE (`TCA_TICK_CYCLES)
    ) u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Supply detect and search outcome come from outside this clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vdd_s1    <= 1'b0;
            vdd_s2    <= 1'b0;
            vdd_prev  <= 1'b0;
            srch_s1   <= 1'b0;
            srch_s2   <= 1'b0;
            srch_prev <= 1'b0;
        end else begin
            vdd_s1    <= vdd_present;
            vdd_s2    <= vdd_s1;
            vdd_prev  <= vdd_s2;
            srch_s1   <= search_done;
            srch_s2   <= srch_s1;
            srch_prev <= srch_s2;
        end
    end

    wire vdd_lost   = vdd_prev & ~vdd_s2;
    wire srch_pulse = srch_s2 & ~srch_prev;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire       bus_take  = hsel & hready & htrans[1];
    wire       take_wr   = bus_take & hwrite;
    wire       take_rd   = bus_take & ~hwrite;
    wire [7:0] take_addr = haddr[7:0];
    wire       mapped    = (haddr[31:8] == 24'h000000) &
                           (take_addr[1:0] == 2'b00) &
                           (take_addr <= `TCA_OFS_NV_SCHEME);
    wire       wr_cfg1   = wr_pend & (wr_addr == `TCA_OFS_CFG1);
    wire       wr_cmd    = wr_pend & (wr_addr == `TCA_OFS_COMMAND);
    wire       cmd_start = wr_cmd & hwdata[`TCA_CMD_START_BIT];
    wire       cmd_srch  = wr_cmd & hwdata[`TCA_CMD_SEARCH_BIT];
    wire [2:0] cfg_scheme = cfg1[2:0];
    wire       cfg_avg   = cfg1[`TCA_CFG1_AVG_BIT];
    wire       alert_mode = cfg1[`TCA_CFG1_AMODE_BIT];
    wire       pin_en    = cfg1[`TCA_CFG1_PINEN_BIT];

    // supply powered any nonzero scheme runs continuous
    wire cont_mode = vdd_s2 & (run_scheme != `TCA_SCHEME_ONESHOT);
    // auto scheme measures without request, bus powered only
    wire auto_mode = ~vdd_s2 & (run_scheme == `TCA_SCHEME_AUTO);
    wire stag_mode = ~vdd_s2 & (run_scheme == `TCA_SCHEME_STAGGER);

    // Status word assembled for reads
    wire [31:0] status_word = {26'h0, cont_mode, vdd_s2,
                               (state != TCA_IDLE), low_flag,
                               high_flag, alert_flag};

    // Read mux, unmapped reads return zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (take_addr)
            `TCA_OFS_CFG1:       rd_mux = {26'h0, cfg1};
            `TCA_OFS_CFG2:       rd_mux = {24'h0, hyst};
            `TCA_OFS_LIMIT_LOW:  rd_mux = {16'h0, limit_low};
            `TCA_OFS_LIMIT_HIGH: rd_mux = {16'h0, limit_high};
            `TCA_OFS_RESULT:     rd_mux = {16'h0, result};
            `TCA_OFS_STATUS:     rd_mux = status_word;
            `TCA_OFS_RATE:       rd_mux = {16'h0, rate};
            `TCA_OFS_SHORT_ADDR: rd_mux = {24'h0, short_addr};
            `TCA_OFS_NV_SCHEME:  rd_mux = {29'h0, nv_scheme};
            default:             rd_mux = 32'h00000000;
        endcase
    end

    // Address phase capture, read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend      <= 1'b0;
            rd_stat_pend <= 1'b0;
            wr_addr      <= 8'h00;
            hrdata       <= 32'h00000000;
        end else begin
            wr_pend      <= take_wr & mapped;
            rd_stat_pend <= take_rd & (take_addr == `TCA_OFS_STATUS);
            wr_addr      <= take_addr;
            if (take_rd)
                hrdata <= mapped ? rd_mux : 32'h00000000;
        end
    end

    // Zero wait states and OKAY always
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // reset leaves the one-shot scheme selected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg1       <= 6'h00;
            hyst       <= 8'h00;
            limit_low  <= `TCA_RST_LIMIT_LOW;
            limit_high <= `TCA_RST_LIMIT_HIGH;
            rate       <= `TCA_RST_RATE;
            short_addr <= 8'h00;
            nv_scheme  <= `TCA_SCHEME_ONESHOT;
        end else if (vdd_lost) begin
            // fall back to the stored scheme
            cfg1[2:0] <= nv_scheme;
        end else if (wr_pend) begin
            case (wr_addr)
                `TCA_OFS_CFG1:       cfg1       <= hwdata[5:0];
                `TCA_OFS_CFG2:       hyst       <= hwdata[7:0];
                `TCA_OFS_LIMIT_LOW:  limit_low  <= hwdata[15:0];
                `TCA_OFS_LIMIT_HIGH: limit_high <= hwdata[15:0];
                `TCA_OFS_RATE:       rate       <= hwdata[15:0];
                `TCA_OFS_SHORT_ADDR: short_addr <= hwdata[7:0];
                `TCA_OFS_NV_SCHEME:  nv_scheme  <= hwdata[2:0];
                default:             rate       <= rate;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Measurement sequencer
    // ------------------------------------------------------------------
    // Start request is remembered until the sequencer takes it
    // start ignored while continuous
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            start_pend <= 1'b0;
        else if (cmd_start & ~cont_mode)
            start_pend <= 1'b1;
        else if ((state == TCA_IDLE) | cont_mode)
            start_pend <= 1'b0;
    end

    // Scheme in force is copied only while idle
    wire       idle_go  = start_pend | cont_mode | auto_mode;
    wire [15:0] stag_dly = {4'h0, short_addr, 4'h0};
    wire [18:0] next_sum = sum + {{3{sample_value[15]}}, sample_value};
    wire        last_smp = ~run_avg |
                           (sample_cnt == 4'(`TCA_AVG_SAMPLES - 1));
    wire [15:0] avg_val  = next_sum[18:3];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state      <= TCA_IDLE;
            wait_cnt   <= 16'h0000;
            sample_cnt <= 4'h0;
            sum        <= 19'h00000;
            run_scheme <= `TCA_SCHEME_ONESHOT;
            run_avg    <= 1'b0;
            result     <= 16'h0000;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            case (state)
                TCA_IDLE: begin
                    // scheme and rate taken between measurements
                    run_scheme <= cfg_scheme;
                    run_avg    <= cfg_avg;
                    sample_cnt <= 4'h0;
                    sum        <= 19'h00000;
                    if (idle_go) begin
                        state <= TCA_WAIT;
                        // staggered start offset by short address
                        wait_cnt <= cont_mode ? rate :
                                    stag_mode ? stag_dly : 16'h0000;
                    end
                end
                TCA_WAIT: begin
                    if (wait_cnt == 16'h0000)
                        state <= TCA_MEASURE;
                    else if (tick)
                        wait_cnt <= wait_cnt - 1'b1;
                end
                TCA_MEASURE: begin
                    // one sample, or eight when averaging
                    if (sample_done) begin
                        sum        <= next_sum;
                        sample_cnt <= sample_cnt + 1'b1;
                        if (last_smp) begin
                            result <= run_avg ? avg_val : sample_value;
                            state  <= TCA_CHECK;
                        end
                    end
                end
                TCA_CHECK: begin
                    // back to shutdown after one measurement
                    done_pulse <= 1'b1;
                    state      <= TCA_IDLE;
                end
                default: state <= TCA_IDLE;
            endcase
        end
    end

    // Core request and activity drive
    // One request per sample, so a slow core is never restarted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_req     <= 1'b0;
            req_wait       <= 1'b0;
            active_measure <= 1'b0;
        end else begin
            sample_req     <= (state == TCA_MEASURE) & ~sample_done &
                              ~sample_req & ~req_wait;
            req_wait       <= sample_req | (req_wait & ~sample_done);
            active_measure <= (state == TCA_MEASURE);
        end
    end

    // ------------------------------------------------------------------
    // Threshold check
    // ------------------------------------------------------------------
    // signed compare of result and limits
    wire signed [16:0] res_s   = {result[15], result};
    wire signed [16:0] hi_s    = {limit_high[15], limit_high};
    wire signed [16:0] lo_s    = {limit_low[15], limit_low};
    wire signed [16:0] hy_s    = {9'h000, hyst};
    wire               over_hi = res_s > hi_s;
    wire               under_lo = res_s < lo_s;
    wire               trip    = over_hi | under_lo;
    wire               release_ok = (res_s < (hi_s - hy_s)) &
                                    (res_s > (lo_s + hy_s));
    wire               clr_latch = rd_stat_pend | cmd_srch | srch_pulse;

    // update flags after every measurement, set beats clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_flag <= 1'b0;
            high_flag  <= 1'b0;
            low_flag   <= 1'b0;
        end else if (done_pulse & trip) begin
            alert_flag <= 1'b1;
            high_flag  <= over_hi;
            low_flag   <= under_lo;
        end else if (alert_mode) begin
            if (done_pulse & release_ok) begin
                alert_flag <= 1'b0;
                high_flag  <= 1'b0;
                low_flag   <= 1'b0;
            end
        end else if (clr_latch) begin
            alert_flag <= 1'b0;
            high_flag  <= 1'b0;
            low_flag   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Alert pin
    // ------------------------------------------------------------------
    // open drain low, supply powered only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_pin_oe  <= 1'b0;
            alert_pin_out <= 1'b0;
        end else begin
            alert_pin_oe  <= vdd_s2 & pin_en & alert_flag;
            alert_pin_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    cont_ignore_a: assert property (
        (cmd_start & cont_mode) |=> !start_pend)
        else $error("start taken in continuous scheme");
    latch_hold_a: assert property (
        (alert_flag & !alert_mode & !clr_latch & !done_pulse)
        |=> alert_flag)
        else $error("latched alert dropped early");
    trip_set_a: assert property (
        (done_pulse & trip) |=> alert_flag)
        else $error("alert not set on crossing");
    pin_gate_a: assert property (
        alert_pin_oe |-> $past(vdd_s2) && !alert_pin_out)
        else $error("pin driven while bus powered");
    one_meas_a: assert property (
        (state == TCA_CHECK) |=> (state == TCA_IDLE))
        else $error("did not return to shutdown");
    comp_rel_a: assert property (
        (alert_mode & done_pulse & release_ok & !trip) |=> !alert_flag)
        else $error("comparator alert not released");
    srch_clr_a: assert property (
        (srch_pulse & !alert_mode & !(done_pulse & trip))
        |=> !alert_flag)
        else $error("search did not clear alert");
    okay_resp_a: assert property (
        hreadyout && !hresp)
        else $error("bus response not okay");

    meas_cov: cover property (state == TCA_MEASURE ##1 state == TCA_CHECK);
    trip_cov: cover property (done_pulse & trip);
    pin_cov: cover property (alert_pin_oe);
endmodule

// ==== tca_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the measurement and alert block
// Assumes: Zero wait bus slave, sensor model on the core side
// Notes:   Temperatures drawn from a fixed seed
`timescale 1ns/10ps
`include "tca_cfg.svh"
module tca_ctrl_tb_top;
    logic               hclk, hresetn, hsel, hwrite, hready, vdd_present;
    logic               search_done, sample_done, sample_req;
    logic               active_measure, alert_pin_oe, alert_pin_out;
    logic               hreadyout, hresp, slow, spread;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic [15:0]        sample_value, base;
    logic [31:0]        haddr, hwdata, hrdata, q;
    logic signed [15:0] v;
    int                 err_count, n_tests, seed, k, i;
    logic [7:0]         ra[5] = '{8'h08, 8'h0C, 8'h1C, 8'h00, 8'h3C};
    logic [31:0]        rv[5] = '{32'h8000, 32'h7FFF, 32'h10, 32'h0, 32'h0};
    logic [15:0]        cv[3] = '{16'd101, 16'd98, 16'd95};
    logic               ce[3] = '{1'b1, 1'b1, 1'b0};

    assign hready = hreadyout;
    tca_ctrl #(.SLOT_TICKS(32)) tca_ctrl_i (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .vdd_present, .search_done, .sample_done,
        .sample_value, .sample_req, .active_measure, .alert_pin_oe,
        .alert_pin_out);
    tca_sensor_model tca_sensor_model_i (.hclk, .hresetn, .sample_req,
        .slow, .spread, .base, .sample_done, .sample_value);

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic hit(input logic signed [15:0] x, lo, hi);
        return (x > hi) || (x < lo);
    endfunction

    // ------------------------------------------------------------
    // Bus cycle and measurement wait
    // ------------------------------------------------------------
    // Address phase held until hready, then data phase until hready
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do begin @(posedge hclk); t++; end while (hready !== 1'b1 && t < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); t++; end while (hready !== 1'b1 && t < 50);
        q = hrdata;
        if (t >= 50) begin
            err_count++;
            tally_and_finish;
        end
    endtask
    // Bounded: a measurement that never starts or ends fails the run
    task automatic wait_meas;
        int t;
        t = 0;
        while (active_measure !== 1'b1 && t < 4000) begin
            @(negedge hclk);
            t++;
        end
        if (t >= 4000)
            t = 8000;
        while (active_measure !== 1'b0 && t < 8000) begin
            @(negedge hclk);
            t++;
        end
        repeat (4) @(posedge hclk);
        if (t >= 8000) begin
            err_count++;
            tally_and_finish;
        end
    endtask
    task automatic go;
        ahb(1'b1, `TCA_OFS_COMMAND, 32'h1);
        wait_meas;
    endtask

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, vdd_present, search_done} = 5'h0;
        {slow, spread, htrans, haddr, hwdata, base} = '0;
        hsize = 3'h2;
        seed = 24633;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            ahb(1'b0, ra[i], 32'h0);
            chk("reset_reg", q, rv[i]);
        end
        ahb(1'b1, `TCA_OFS_LIMIT_LOW, 32'hFF38);
        ahb(1'b1, `TCA_OFS_LIMIT_HIGH, 32'h00C8);
        ahb(1'b1, `TCA_OFS_CFG1, 32'h20);
        // Latched one-shot trials; trial 0 is a negative corner
        for (i = 0; i < 8; i++) begin
            v = (i == 0) ? -16'sd100 : 16'($random(seed)) % 16'sd300;
            base        <= v;
            slow        <= 1'($random(seed));
            vdd_present <= 1'($random(seed));
            repeat (4) @(posedge hclk);
            go;
            ahb(1'b0, `TCA_OFS_RESULT, 32'h0);
            chk("result", q, {16'h0, v});
            chk("pin", alert_pin_oe, vdd_present & hit(v,-200,200));
            chk("pin_out", alert_pin_out, 1'b0);
            if (i[0]) begin
                search_done <= 1'b1;
                repeat (4) @(posedge hclk);
                search_done <= 1'b0;
                repeat (4) @(posedge hclk);
            end
            ahb(1'b0, `TCA_OFS_STATUS, 32'h0);
            chk("alert", q[0], !i[0] && hit(v,-200,200));
            ahb(1'b0, `TCA_OFS_STATUS, 32'h0);
            chk("alert_clr", q[0], 1'b0);
        end
        ahb(1'b1, `TCA_OFS_CFG1, 32'h08);
        spread <= 1'b1;
        base   <= 16'($random(seed)) & 16'h0FFF;
        go;
        ahb(1'b0, `TCA_OFS_RESULT, 32'h0);
        chk("average", q, {16'h0, base + 16'h3});
        spread <= 1'b0;
        ahb(1'b1, `TCA_OFS_CFG1, 32'h10);
        ahb(1'b1, `TCA_OFS_CFG2, 32'h4);
        ahb(1'b1, `TCA_OFS_LIMIT_HIGH, 32'h64);
        for (i = 0; i < 3; i++) begin
            base <= cv[i];
            go;
            ahb(1'b0, `TCA_OFS_STATUS, 32'h0);
            chk("comparator", q[0], ce[i]);
        end
        base <= 16'h0042;
        vdd_present <= 1'b0;
        ahb(1'b1, `TCA_OFS_CFG1, 32'h02);
        ahb(1'b0, `TCA_OFS_RESULT, 32'h0);
        wait_meas;
        ahb(1'b0, `TCA_OFS_RESULT, 32'h0);
        chk("auto", q, 32'h42);
        vdd_present <= 1'b1;
        ahb(1'b1, `TCA_OFS_CFG1, 32'h01);
        base <= 16'h0123;
        wait_meas;
        wait_meas;
        ahb(1'b0, `TCA_OFS_RESULT, 32'h0);
        chk("continuous", q, 32'h123);
        ahb(1'b0, `TCA_OFS_STATUS, 32'h0);
        chk("cont_flag", q[5], 1'b1);
        vdd_present <= 1'b0;
        wait_meas;
        ahb(1'b0, `TCA_OFS_CFG1, 32'h0);
        chk("restore_cfg", q, 32'h0);
        k = 0;
        repeat (3000) begin
            @(posedge hclk);
            if (active_measure !== 1'b0)
                k++;
        end
        chk("scheme_restore", k, 0);
        tally_and_finish;
    end
endmodule

// ==== tca_pkg.sv ====
// Purpose: Types for the temperature measurement and alert control block
// Assumes: Included configuration header supplies numbers
// Notes:   Types only
package tca_pkg;
    typedef enum logic [3:0] {
        TCA_IDLE    = 4'b0001,
        TCA_WAIT    = 4'b0010,
        TCA_MEASURE = 4'b0100,
        TCA_CHECK   = 4'b1000
    } tca_state_type;
endpackage

// ==== tca_sensor_model.sv ====
// Purpose: Sensor core model answering each sample request once
// Assumes: Same clock as the control block
// Notes:   Value line toggles while no sample request is pending
`timescale 1ns/10ps
module tca_sensor_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        sample_req,
    input  wire logic        slow,
    input  wire logic        spread,
    input  wire logic [15:0] base,
    output logic             sample_done,
    output logic [15:0]      sample_value
);
    int         wait_cnt;
    logic       pend;
    logic [2:0] seq;

    // ------------------------------------------------------------
    // Answer after a short or long delay
    // ------------------------------------------------------------
    // Spread adds a running 0..7 step so averages are not trivial
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend         <= 1'b0;
            wait_cnt     <= 0;
            seq          <= 3'h0;
            sample_done  <= 1'b0;
            sample_value <= 16'h0000;
        end else begin
            sample_done <= 1'b0;
            if (sample_req) begin
                pend     <= 1'b1;
                wait_cnt <= slow ? 20 : 1;
            end else if (pend && wait_cnt > 0) begin
                wait_cnt <= wait_cnt - 1;
            end else if (pend) begin
                pend         <= 1'b0;
                sample_done  <= 1'b1;
                sample_value <= base + (spread ? {13'h0, seq} : 16'h0);
                seq          <= seq + 3'h1;
            end else begin
                sample_value <= ~sample_value; // Not valid between samples
            end
        end
    end
endmodule

// ==== tca_tick_div.sv ====
// Purpose: Divider making a one-cycle enable pulse every N clocks
// Assumes: Single clock domain
// Notes:   Pulse is registered
`timescale 1ns/10ps
module tca_tick_div #(
    parameter int DIVIDE = 50
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      tick
);
    localparam int CW = $clog2(DIVIDE + 1);
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    logic [CW-1:0] count;
    wire           wrap = (count == LAST);

    // ------------------------------------------------------------------
    // Counter and pulse
    // ------------------------------------------------------------------
    // Free running so tick spacing stays fixed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= wrap ? '0 : count + 1'b1;
            tick  <= wrap;
        end
    end
endmodule
